// ===== include/fmc_pkg.sv
// Constants shared by the field and modulation controller.
package fmc_pkg;
  // ==========================================================================
  // Timing.
  localparam int unsigned CLK_PERIOD_NS  = 10;
  localparam int unsigned SAMPLE_TIME_US = 125;
  localparam int unsigned SAMPLE_CYCLES  = SAMPLE_TIME_US * 1000 / CLK_PERIOD_NS;

  // ==========================================================================
  // Scaling of settings: percent in 0.01 %, gain in 0.1, times in 0.1 ms.
  localparam int unsigned PCT_FULL   = 10000;
  localparam int unsigned GAIN_SCALE = 10;
  localparam int unsigned TI_UNIT_US = 100;

  // ==========================================================================
  // Default settings for the parameter store.
  localparam logic [15:0] FIELD_GAIN_RST  = 16'h0032;
  localparam logic [15:0] FIELD_TI_RST    = 16'h03E8;
  localparam logic [15:0] FLUX_FACTOR_RST = 16'h2710;
  localparam logic [15:0] ISD_LOWER_RST   = 16'h0000;
  localparam logic [15:0] MOD_REF_RST     = 16'h27D8;
  localparam logic [15:0] MOD_TI_RST      = 16'h0064;
  localparam logic [15:0] DEV_LIM_RST     = 16'h03E8;

  // ==========================================================================
  // Modulation source selection.
  localparam logic MODE_USQ  = 1'b0;
  localparam logic MODE_VABS = 1'b1;

  // ==========================================================================
  // Output reset values and saturation.
  localparam logic [15:0] OUT_RST  = 16'h0000;
  localparam logic [15:0] MOD_SAT  = 16'hFFFF;
  localparam logic [15:0] CUR_SAT  = 16'h7FFF;

  typedef enum logic [3:0] {
    FMC_IDLE  = 4'b0001,
    FMC_MOD   = 4'b0010,
    FMC_FLUX  = 4'b0100,
    FMC_FIELD = 4'b1000
  } fmc_state_t;
endpackage

// ===== hw/fmc_clamp.sv
// Saturating clamp of a wide signed value into a 16-bit window.
`timescale 1ns/100ps
`default_nettype none
module fmc_clamp #(
  parameter int IW = 48
) (
  input  wire logic signed [IW-1:0] val,
  input  wire logic signed [15:0]   lo,
  input  wire logic signed [15:0]   hi,
  output logic signed [15:0]        y
);
  // The lower bound wins when the window is inverted, so a bad limit pair never
  // lets the value fall below the floor.
  always_comb begin
    if (val < IW'(lo)) begin
      y = lo;
    end else if (val > IW'(hi)) begin
      y = (hi < lo) ? lo : hi;
    end else begin
      y = val[15:0];
    end
  end
endmodule
`default_nettype wire

// ===== hw/fmc_top.sv
// Field controller and modulation controller for a vector drive.
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// - PI loop on flux current with gain and integral time settings.
// - Flux factor scales the flux setpoint through the magnetizing current cap.
// - Field output, integral and proportional parts clamp between isd limits.
// - Modulation controller is integral only, no proportional path.
// - Modulation above its reference lowers the flux reference.
// - Mode 0 uses usq over dc link, mode 1 uses absolute voltage.
// - Modulation controller integral time is programmable, zero freezes it.
// - Flux reference and its integral clamp between lower limit and rated times factor.
// - Modulation deviation clamps symmetrically to plus and minus its limit.
module fmc_top
  import fmc_pkg::*;
#(
  parameter int unsigned SAMPLE_CYC = SAMPLE_CYCLES
) (
  input  wire logic               clk,
  input  wire logic               resetn,
  input  wire logic               mod_mode,
  input  wire logic [15:0]        mod_ref,
  input  wire logic [15:0]        mod_ti,
  input  wire logic [15:0]        dev_lim,
  input  wire logic [15:0]        imr_rated,
  input  wire logic signed [15:0] imr_lower,
  input  wire logic [15:0]        flux_factor,
  input  wire logic [15:0]        field_gain,
  input  wire logic [15:0]        field_ti,
  input  wire logic signed [15:0] isd_upper,
  input  wire logic signed [15:0] isd_lower,
  input  wire logic signed [15:0] usq,
  input  wire logic signed [15:0] u_abs,
  input  wire logic [15:0]        u_dc,
  input  wire logic signed [15:0] imr_act,
  output logic signed [15:0]      isd_ref,
  output logic signed [15:0]      imr_ref,
  output logic [15:0]             mod_meas,
  output logic                    upd_done
);
  // ==========================================================================
  // Sample tick.
  localparam int CW = $clog2(SAMPLE_CYC + 1);
  localparam logic [CW-1:0] CNT_LAST = CW'(SAMPLE_CYC - 1);
  localparam logic signed [47:0] TS_S    = 48'(SAMPLE_TIME_US);
  localparam logic signed [47:0] MOD_DEN = 48'(TI_UNIT_US * PCT_FULL);
  localparam logic signed [47:0] FLD_DEN = 48'(TI_UNIT_US * GAIN_SCALE);
  localparam logic signed [31:0] GSC_S   = 32'(GAIN_SCALE);

  logic [CW-1:0] cnt_q;
  logic          tick_q;
  fmc_state_t    st_q;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_q  <= '0;
      tick_q <= 1'b0;
    end else begin
      tick_q <= (cnt_q == CNT_LAST);
      cnt_q  <= (cnt_q == CNT_LAST) ? '0 : cnt_q + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_q <= FMC_IDLE;
    end else begin
      unique case (st_q)
        FMC_IDLE:  st_q <= tick_q ? FMC_MOD : FMC_IDLE;
        FMC_MOD:   st_q <= FMC_FLUX;
        FMC_FLUX:  st_q <= FMC_FIELD;
        FMC_FIELD: st_q <= FMC_IDLE;
        default:   st_q <= FMC_IDLE;
      endcase
    end
  end

  // ==========================================================================
  // Modulation measurement.
  logic signed [15:0] vsel;
  logic [15:0]        vmag;
  logic [31:0]        mod_full;
  logic [15:0]        udc_safe;
  logic [15:0]        mod_d;
  logic [15:0]        mod_q;

  assign vsel     = (mod_mode == MODE_VABS) ? u_abs : usq;
  assign vmag     = vsel[15] ? 16'(-vsel) : vsel;
  assign udc_safe = (u_dc == '0) ? 16'h0001 : u_dc;
  assign mod_full = (32'(vmag) * 32'(PCT_FULL)) / 32'(udc_safe);
  // A dead DC link reads as the saturated modulation MOD_SAT, which drives the flux down.
  assign mod_d    = ((u_dc == '0) || (mod_full > 32'(MOD_SAT))) ? MOD_SAT : mod_full[15:0];

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mod_q <= OUT_RST;
    end else if (st_q == FMC_MOD) begin
      mod_q <= mod_d;
    end
  end

  // ==========================================================================
  // Modulation controller, integral only.
  logic signed [17:0] dev_raw;
  logic signed [15:0] dev_c;
  logic signed [15:0] lim_s;
  logic [31:0]        capw;
  logic signed [15:0] cap;
  logic signed [47:0] inc_m;
  logic signed [47:0] den_m;
  logic signed [47:0] imr_sum;
  logic signed [15:0] imr_d;
  logic signed [15:0] imr_q;

  assign dev_raw = $signed({2'b00, mod_ref}) - $signed({2'b00, mod_q});
  assign lim_s   = $signed({1'b0, dev_lim[14:0]});

  fmc_clamp #(.IW(18)) u_dev (
    .val (dev_raw),
    .lo  (-lim_s),
    .hi  (lim_s),
    .y   (dev_c)
  );

  assign capw  = (32'(imr_rated) * 32'(flux_factor)) / 32'(PCT_FULL);
  assign cap   = (capw > 32'(CUR_SAT)) ? CUR_SAT : capw[15:0];
  assign den_m = (mod_ti == '0) ? 48'sd1 : $signed(48'(mod_ti)) * MOD_DEN;
  // Truncation toward zero leaves deviations below one step unintegrated.
  assign inc_m = (mod_ti == '0) ? 48'sd0
               : (48'(dev_c) * $signed(48'(cap)) * TS_S) / den_m;
  assign imr_sum = 48'(imr_q) + inc_m;

  fmc_clamp #(.IW(48)) u_imr (
    .val (imr_sum),
    .lo  (imr_lower),
    .hi  (cap),
    .y   (imr_d)
  );

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      imr_q <= OUT_RST;
    end else if (st_q == FMC_FLUX) begin
      imr_q <= imr_d;
    end
  end

  // ==========================================================================
  // Field controller, proportional and integral.
  logic signed [16:0] err_f;
  logic signed [31:0] p_raw;
  logic signed [15:0] p_c;
  logic signed [47:0] den_f;
  logic signed [47:0] inc_f;
  logic signed [47:0] i_sum;
  logic signed [15:0] i_c;
  logic signed [16:0] tot;
  logic signed [15:0] isd_d;
  logic signed [15:0] isd_i_q;
  logic signed [15:0] isd_q;

  assign err_f = 17'(imr_q) - 17'(imr_act);
  assign p_raw = ($signed(32'(field_gain)) * 32'(err_f)) / GSC_S;
  assign den_f = (field_ti == '0) ? 48'sd1 : $signed(48'(field_ti)) * FLD_DEN;
  // Integral time zero freezes the integral part at its held value rather than dividing by zero.
  assign inc_f = (field_ti == '0) ? 48'sd0
               : ($signed(48'(field_gain)) * 48'(err_f) * TS_S) / den_f;
  assign i_sum = 48'(isd_i_q) + inc_f;
  assign tot   = 17'(p_c) + 17'(i_c);

  fmc_clamp #(.IW(32)) u_p (
    .val (p_raw),
    .lo  (isd_lower),
    .hi  (isd_upper),
    .y   (p_c)
  );

  fmc_clamp #(.IW(48)) u_i (
    .val (i_sum),
    .lo  (isd_lower),
    .hi  (isd_upper),
    .y   (i_c)
  );

  fmc_clamp #(.IW(17)) u_out (
    .val (tot),
    .lo  (isd_lower),
    .hi  (isd_upper),
    .y   (isd_d)
  );

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      isd_i_q <= OUT_RST;
      isd_q   <= OUT_RST;
    end else if (st_q == FMC_FIELD) begin
      isd_i_q <= i_c;
      isd_q   <= isd_d;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      upd_done <= 1'b0;
    end else begin
      upd_done <= (st_q == FMC_FIELD);
    end
  end

  assign isd_ref  = isd_q;
  assign imr_ref  = imr_q;
  assign mod_meas = mod_q;

  // ==========================================================================
  // Checks.
  AST_ISD_WINDOW: assert property (@(posedge clk) disable iff (!resetn)
    (st_q == FMC_FIELD) && (isd_lower <= isd_upper) |=>
      (isd_q >= $past(isd_lower)) && (isd_q <= $past(isd_upper)))
    else $error("flux current reference outside its limits");

  AST_ISD_HOLD: assert property (@(posedge clk) disable iff (!resetn)
    (st_q != FMC_FIELD) |=> $stable(isd_q) && $stable(isd_i_q))
    else $error("field controller moved outside its update slot");

  AST_IMR_WINDOW: assert property (@(posedge clk) disable iff (!resetn)
    (st_q == FMC_FLUX) && (imr_lower <= cap) |=>
      (imr_q >= $past(imr_lower)) && (imr_q <= $past(cap)))
    else $error("flux reference outside its limits");

  AST_CAP: assert property (@(posedge clk) disable iff (!resetn)
    (flux_factor == 16'(PCT_FULL)) && (imr_rated <= CUR_SAT) |->
      (cap == $signed(imr_rated)))
    else $error("flux factor of one does not give rated current");

  AST_DEV_WINDOW: assert property (@(posedge clk) disable iff (!resetn)
    (dev_c <= lim_s) && (dev_c >= -lim_s))
    else $error("modulation deviation exceeds its limit");

  AST_FLUX_DOWN: assert property (@(posedge clk) disable iff (!resetn)
    (st_q == FMC_FLUX) && (mod_q > mod_ref) && (imr_q <= cap) &&
      (imr_q >= imr_lower) |=> (imr_q <= $past(imr_q)))
    else $error("flux rose while modulation was above reference");

  AST_TI_FREEZE: assert property (@(posedge clk) disable iff (!resetn)
    (st_q == FMC_FLUX) && (mod_ti == '0) && (imr_q <= cap) &&
      (imr_q >= imr_lower) |=> $stable(imr_q))
    else $error("flux reference moved with integral time zero");

  AST_MODE0: assert property (@(posedge clk) disable iff (!resetn)
    (st_q == FMC_MOD) && (mod_mode == MODE_USQ) && (usq == '0) &&
      (u_dc != '0) |=> (mod_q == '0))
    else $error("mode zero did not follow the torque voltage");

  AST_SEQ: assert property (@(posedge clk) disable iff (!resetn)
    tick_q && (st_q == FMC_IDLE) |=> (st_q == FMC_MOD) ##1 (st_q == FMC_FLUX)
      ##1 (st_q == FMC_FIELD) ##1 upd_done)
    else $error("sample sequence broken");

  AST_NO_P: assert property (@(posedge clk) disable iff (!resetn)
    (st_q != FMC_FLUX) |=> $stable(imr_q))
    else $error("flux reference changed outside its integral step");
endmodule
`default_nettype wire

// ===== verification/fmc_far_model.sv
// Model of the current-control side that feeds measured voltages and current.
`timescale 1ns/100ps
`default_nettype none
module fmc_far_model (
  output logic               mod_mode,
  output logic signed [15:0] usq,
  output logic signed [15:0] u_abs,
  output logic [15:0]        u_dc,
  output logic signed [15:0] imr_act
);
  // ==========================================================================
  // Measurements.
  // Values change only when the bench calls put just after an edge.
  // A sample then never sees a half-applied set.
  initial begin
    put(1'b0, 16'sh0000, 16'sh0000, 16'h2710, 16'sh0000);
  end

  task automatic put(input logic m, input logic signed [15:0] q, input logic signed [15:0] a,
                     input logic [15:0] d, input logic signed [15:0] i);
    mod_mode = m;
    usq = q;
    u_abs = a;
    u_dc = d;
    imr_act = i;
  endtask
endmodule
`default_nettype wire

// ===== verification/test_fmc_top.sv
// Self-checking bench for the field and modulation controller.
`timescale 1ns/100ps
`default_nettype none
module test_fmc_top;
  import fmc_pkg::*;
  localparam int SCYC = 20;
  logic               clk = 1'b0;
  logic               resetn = 1'b0;
  logic [15:0]        mod_ref, mod_ti, dev_lim, imr_rated, flux_factor, field_gain, field_ti;
  logic signed [15:0] imr_lower, isd_upper, isd_lower, isd_ref, imr_ref;
  logic signed [15:0] usq, u_abs, imr_act;
  logic [15:0]        u_dc, mod_meas;
  logic               mod_mode, upd_done, seen;
  int                 mismatches, checks_done, i;
  longint             imr_e, i_e;

  always #5 clk = ~clk;

  fmc_far_model far_u (.mod_mode(mod_mode), .usq(usq), .u_abs(u_abs), .u_dc(u_dc),
                       .imr_act(imr_act));
  fmc_top #(.SAMPLE_CYC(SCYC)) dut_u (.clk(clk), .resetn(resetn), .mod_mode(mod_mode),
    .mod_ref(mod_ref), .mod_ti(mod_ti), .dev_lim(dev_lim), .imr_rated(imr_rated),
    .imr_lower(imr_lower), .flux_factor(flux_factor), .field_gain(field_gain),
    .field_ti(field_ti), .isd_upper(isd_upper), .isd_lower(isd_lower), .usq(usq),
    .u_abs(u_abs), .u_dc(u_dc), .imr_act(imr_act), .isd_ref(isd_ref), .imr_ref(imr_ref),
    .mod_meas(mod_meas), .upd_done(upd_done));

  // ==========================================================================
  // Checking helpers.
  task automatic chk(input string nm, input logic [15:0] seen_v, input logic [15:0] exp_v);
    checks_done++;
    if (seen_v !== exp_v) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, exp_v, seen_v);
    end
  endtask

  task automatic final_report();
    if (mismatches == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  function automatic longint clampl(input longint x, input longint lo, input longint hi);
    if (x > hi) x = hi;
    if (x < lo) x = lo;
    return x;
  endfunction

  task automatic wait_upd();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (upd_done !== 1'b1 && n < 50);
    if (n >= 50) begin
      mismatches++;
      final_report();
    end else if (seen) begin
      chk("period", 16'(n), 16'(SCYC));
    end
    seen = 1'b1;
  endtask

  // One sample period: the model mirrors both loops in wide integers.
  task automatic sample();
    longint v, m, cap, dev, err, p;
    wait_upd();
    v = mod_mode ? longint'(u_abs) : longint'(usq);
    if (v < 0) v = -v;
    m = (u_dc == 16'h0000) ? 65535 : v * 10000 / longint'(u_dc);
    if (m > 65535) m = 65535;
    cap = clampl(longint'(imr_rated) * longint'(flux_factor) / 10000, 0, 32767);
    dev = clampl(longint'(mod_ref) - m, -longint'(dev_lim[14:0]), longint'(dev_lim[14:0]));
    if (mod_ti != 16'h0000) imr_e = imr_e + dev * cap * 125 / (longint'(mod_ti) * 1000000);
    imr_e = clampl(imr_e, imr_lower, cap);
    err = imr_e - longint'(imr_act);
    if (field_ti != 16'h0000) begin
      i_e = i_e + longint'(field_gain) * err * 125 / (longint'(field_ti) * 1000);
    end
    i_e = clampl(i_e, isd_lower, isd_upper);
    p = clampl(longint'(field_gain) * err / 10, isd_lower, isd_upper);
    chk("mod_meas", mod_meas, 16'(m));
    chk("imr_ref", imr_ref, 16'(imr_e));
    chk("isd_ref", isd_ref, 16'(clampl(p + i_e, isd_lower, isd_upper)));
  endtask

  // ==========================================================================
  // Main sequence.
  initial begin
    mismatches = 0;
    checks_done = 0;
    seen = 1'b0;
    imr_e = 0;
    i_e = 0;
    void'($urandom(32'hfd70));
    mod_ref = MOD_REF_RST;
    mod_ti = 16'h0001;
    dev_lim = DEV_LIM_RST;
    imr_rated = 16'h03E8;
    flux_factor = 16'h4E20;
    imr_lower = 16'sh0064;
    field_gain = FIELD_GAIN_RST;
    field_ti = 16'h0000;
    isd_upper = 16'sh7530;
    isd_lower = -16'sh7530;
    repeat (10) @(posedge clk);
    chk("isd_ref", isd_ref, OUT_RST);
    chk("upd_done", 16'(upd_done), 16'h0000);
    #1 resetn = 1'b1;
    // Low modulation raises the flux reference up to rated times factor.
    repeat (10) sample();
    far_u.put(1'b0, 16'sh4E20, 16'sh0000, 16'h2710, 16'sh0000);
    repeat (10) sample();
    mod_ti = 16'h0000;
    for (i = 0; i < 8; i++) begin
      field_gain = 16'($urandom_range(0, 1000));
      isd_upper = 16'($urandom_range(500, 5000));
      isd_lower = -16'($urandom_range(0, 5000));
      mod_ref = 16'($urandom_range(300, 10500));
      far_u.put(1'($urandom), 16'(int'($urandom_range(0, 60000)) - 30000),
                16'(int'($urandom_range(0, 60000)) - 30000),
                (i == 0) ? 16'h0000 : 16'($urandom_range(1, 40000)),
                16'(int'($urandom_range(0, 4000)) - 2000));
      sample();
    end
    field_gain = 16'h000A;
    field_ti = 16'h0001;
    flux_factor = FLUX_FACTOR_RST;
    isd_upper = 16'sh03E8;
    isd_lower = -16'sh03E8;
    far_u.put(1'b0, 16'sh0000, 16'sh0000, 16'h2710, 16'sh0014);
    repeat (12) sample();
    far_u.put(1'b0, 16'sh0000, 16'sh0000, 16'h2710, 16'sh00B4);
    repeat (3) sample();
    // An inverted window must settle on the lower limit.
    isd_lower = 16'sh00C8;
    isd_upper = 16'sh0064;
    repeat (2) sample();
    final_report();
  end
endmodule
`default_nettype wire
